/* File: hw/adcp_device.sv */
// Purpose: converter end of the parallel port and conversion control
// Assumes: all pins reach here through two flops
// Notes:   analog sample arrives as a code on sample_value
//
// Operation
// R1 - 12 or 10 bit port, word/byte select
// R2 - start falling edge begins conversion, busy high
// R3 - start rising before 14th fall aborts
// R4 - busy falls when conversion completes
// R5 - hold at start fall, track 13th rise
// R6 - host allows 125 ns acquisition first
// R7 - hold after reset until first start rise
// R8 - auto modes power up on start rise
// R9 - word read gives whole word
// R10 - byte mode uses two reads, select chooses
// R11 - low byte gives eight low bits
// R12 - high byte: four msbs, channel bits 5-7
// R13 - bus driven only while select and read low
// R14 - result on bus before busy falls
// R15 - word write loads full control word
// R16 - byte writes low first, then high
// R17 - host zeroes top four high-byte bits
// R18 - shadow write always takes one cycle
// R19 - write taken at write strobe rise
// R20 - two power bits, reset gives normal
// R21 - power bit decode, auto power down
// R22 - full shutdown on write, normal wakes
// R23 - byte write staged until high byte
// R24 - result held until next conversion completes
//
// The plain strobed port and the register offsets were left to the implementer.

`timescale 1ns/10ps

module adcp_device #(
  parameter bit TEN_BIT = 1'b0
) (
  adcp_if.device              link,
  input  wire logic           clk,
  input  wire logic           reset_n,
  input  wire logic [11:0]    sample_value,
  output logic                hold,
  output logic                powered_down,
  output logic [11:0]         control_word,
  output logic [7:0]          channel_mask,
  output logic [11:0]         result_word,
  output logic [2:0]          result_channel
);
  typedef enum logic [1:0] {
    C_IDLE    = 2'b00,
    C_CONVERT = 2'b01,
    C_LOAD    = 2'b10,
    C_RELEASE = 2'b11
  } adcp_cstate_t;

  adcp_cstate_t             state;
  logic [17:0]              raw;
  logic [17:0]              synced;
  logic                     start_s;
  logic                     cclk_s;
  logic                     cs_s;
  logic                     rd_s;
  logic                     wr_s;
  logic                     word_s;
  logic [11:0]              data_s;
  logic                     start_q;
  logic                     cclk_q;
  logic                     wr_act_q;
  logic                     start_fall;
  logic                     start_rise;
  logic                     cclk_rise;
  logic                     cclk_fall;
  logic                     wr_act;
  logic                     wr_done;
  logic                     rd_act;
  logic                     ctl_load;
  logic [11:0]              new_ctl;
  logic [7:0]               staging;
  logic                     shadow_pending;
  logic                     armed;
  logic                     go;
  logic                     auto_mode;
  logic                     busy;
  logic [3:0]               rise_count;
  logic [3:0]               fall_count;
  logic [11:0]              sample_held;
  logic [2:0]               chan_held;
  logic [11:0]              data_out;
  logic [11:0]              data_oe;

  // 10-bit codes sit on the upper ten lines
  function automatic logic [11:0] align(input logic [11:0] code);
    align = TEN_BIT ? {code[9:0], 2'b00} : code; // R1 R11
  endfunction : align

  assign raw = {link.conversion_start_n, link.conversion_clock, link.cs_n,
                link.rd_n, link.wr_n, link.word_mode, link.data_bus};

  adcp_sync #(.WIDTH(18), .RESET_VALUE(18'h2F000)) u_sync (
    .clk     (clk),
    .reset_n (reset_n),
    .d       (raw),
    .q       (synced)
  );

  assign start_s = synced[17];
  assign cclk_s  = synced[16];
  assign cs_s    = synced[15];
  assign rd_s    = synced[14];
  assign wr_s    = synced[13];
  assign word_s  = synced[12];
  assign data_s  = synced[11:0];

  assign link.busy         = busy;
  assign link.dev_data_out = data_out;
  assign link.dev_data_oe  = data_oe;

  assign start_fall = start_q & ~start_s;
  assign start_rise = ~start_q & start_s;
  assign cclk_rise  = ~cclk_q & cclk_s;
  assign cclk_fall  = cclk_q & ~cclk_s;
  assign wr_act     = ~cs_s & ~wr_s;
  assign wr_done    = wr_act_q & ~wr_act; // R19
  assign rd_act     = ~cs_s & ~rd_s; // R13

  // a control load is a word write or the high byte of a pair
  assign ctl_load = wr_done & ~shadow_pending & (word_s | data_s[adcp_pkg::HBS_BIT]);
  assign new_ctl  = word_s ? data_s : {data_s[3:0], staging}; // R15 R16

  assign auto_mode = (adcp_pkg::adcp_power_of(control_word) == adcp_pkg::PM_AUTO_SHUTDOWN) ||
                     (adcp_pkg::adcp_power_of(control_word) == adcp_pkg::PM_AUTO_STANDBY); // R21
  assign go        = start_fall & armed & ~powered_down & (state == C_IDLE); // R2

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      start_q  <= 1'b1;
      cclk_q   <= 1'b0;
      wr_act_q <= 1'b0;
    end else begin
      start_q  <= start_s;
      cclk_q   <= cclk_s;
      wr_act_q <= wr_act;
    end
  end

  // control, shadow and byte staging
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      control_word   <= adcp_pkg::CONTROL_RESET; // R20
      channel_mask   <= adcp_pkg::MASK_RESET;
      staging        <= 8'h00;
      shadow_pending <= 1'b0;
    end else if (wr_done) begin
      if (shadow_pending) begin
        channel_mask   <= data_s[7:0]; // R18
        shadow_pending <= 1'b0;
      end else if (ctl_load) begin
        control_word   <= new_ctl; // R15 R23
        shadow_pending <= new_ctl[adcp_pkg::SHADOW_LOAD_BIT];
      end else begin
        staging <= data_s[7:0]; // R23
      end
    end
  end

  // track/hold and power state
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      armed        <= 1'b0;
      hold         <= 1'b1; // R7
      powered_down <= 1'b0;
    end else if (ctl_load && adcp_pkg::adcp_power_of(new_ctl) == adcp_pkg::PM_FULL_SHUTDOWN) begin
      powered_down <= 1'b1; // R22
      hold         <= 1'b1;
    end else if (ctl_load && powered_down &&
                 adcp_pkg::adcp_power_of(control_word) == adcp_pkg::PM_FULL_SHUTDOWN &&
                 adcp_pkg::adcp_power_of(new_ctl) == adcp_pkg::PM_NORMAL) begin
      powered_down <= 1'b0; // R22
      hold         <= 1'b0;
    end else if (state == C_CONVERT && start_rise) begin
      hold <= 1'b0; // R3
    end else if (state == C_CONVERT && cclk_rise && rise_count == adcp_pkg::TRACK_RISE_EDGE - 4'h1) begin
      hold <= 1'b0; // R5
    end else if (state == C_RELEASE && auto_mode) begin
      powered_down <= 1'b1; // R21
      hold         <= 1'b1;
    end else if (start_rise && state != C_CONVERT) begin
      if (!powered_down || auto_mode) begin
        armed        <= 1'b1; // R7
        powered_down <= 1'b0; // R8
        hold         <= 1'b0;
      end
    end else if (go) begin
      hold <= 1'b1; // R5
    end
  end

  // conversion sequence
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state          <= C_IDLE;
      busy           <= 1'b0;
      rise_count     <= 4'h0;
      fall_count     <= 4'h0;
      sample_held    <= 12'h000;
      chan_held      <= 3'h0;
      result_word    <= adcp_pkg::RESULT_RESET;
      result_channel <= 3'h0;
    end else begin
      case (state)
        C_IDLE: begin
          if (go) begin
            state       <= C_CONVERT;
            busy        <= 1'b1; // R2
            rise_count  <= 4'h0;
            fall_count  <= 4'h0;
            sample_held <= sample_value;
            chan_held   <= control_word[adcp_pkg::CHAN_LSB +: adcp_pkg::CHAN_W];
          end
        end
        C_CONVERT: begin
          if (start_rise) begin
            state <= C_IDLE; // R3
            busy  <= 1'b0;
          end else begin
            if (cclk_rise && rise_count != 4'hF) begin
              rise_count <= rise_count + 4'h1;
            end
            if (cclk_fall) begin
              fall_count <= fall_count + 4'h1;
            end
            if (cclk_fall && fall_count == adcp_pkg::CONV_FALL_EDGE - 4'h1) begin
              state          <= C_LOAD;
              result_word    <= align(sample_held); // R24
              result_channel <= chan_held;
            end
          end
        end
        C_LOAD: begin
          state <= C_RELEASE; // R14
        end
        C_RELEASE: begin
          state <= C_IDLE;
          busy  <= 1'b0; // R4
        end
        default: begin
          state <= C_IDLE;
          busy  <= 1'b0;
        end
      endcase
    end
  end

  // read path
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      data_out <= 12'h000;
      data_oe  <= 12'h000;
    end else begin
      if (word_s) begin
        data_out <= result_word; // R9
      end else if (data_s[adcp_pkg::HBS_BIT]) begin
        data_out <= {4'h0, result_channel, 1'b0, result_word[11:8]}; // R12
      end else begin
        data_out <= {4'h0, result_word[7:0]}; // R11
      end
      if (rd_act) begin
        data_oe <= word_s ? 12'hFFF : 12'h0FF; // R13 R10
      end else begin
        data_oe <= 12'h000;
      end
    end
  end

endmodule : adcp_device

/* File: hw/adcp_host.sv */
// Purpose: host end driving the converter parallel port
// Assumes: commands held to one cycle, taken only while ready
// Notes:   makes the conversion clock by a divider

`timescale 1ns/10ps

module adcp_host (
  adcp_if.host                link,
  input  wire logic           clk,
  input  wire logic           reset_n,
  input  wire logic           cmd_convert,
  input  wire logic           cmd_read,
  input  wire logic           cmd_write,
  input  wire logic           cmd_single,
  input  wire logic [11:0]    cmd_word,
  input  wire logic           word_mode_select,
  output logic                ready,
  output logic                busy_seen,
  output logic                conversion_done,
  output logic                read_valid,
  output logic [11:0]         read_word,
  output logic [2:0]          read_channel
);
  typedef enum logic [2:0] {
    H_PRIME = 3'b000, H_IDLE = 3'b001, H_CONV = 3'b010, H_READ = 3'b011,
    H_WRITE = 3'b100, H_WHOLD = 3'b101, H_GAP = 3'b110
  } adcp_hstate_t;

  adcp_hstate_t state;
  logic [12:0]  synced;
  logic         busy_s;
  logic [11:0]  data_s;
  logic [1:0]   half_cnt;
  logic         cclk;
  logic         cclk_fall_now;
  logic [3:0]   cnt;
  logic [3:0]   acq;
  logic         start_n, cs_n, rd_n, wr_n, word_mode;
  logic [11:0]  out, oe;
  logic         is_write, single, need_high, phase_high;
  logic [11:0]  word_buf;
  logic [7:0]   low_byte;
  logic         take;

  adcp_sync #(.WIDTH(13), .RESET_VALUE(13'h0000)) u_sync (
    .clk(clk), .reset_n(reset_n), .d({link.busy, link.data_bus}), .q(synced));
  assign busy_s = synced[12];
  assign data_s = synced[11:0];

  assign link.conversion_start_n = start_n;
  assign link.conversion_clock   = cclk;
  assign link.cs_n               = cs_n;
  assign link.rd_n               = rd_n;
  assign link.wr_n               = wr_n;
  assign link.word_mode          = word_mode;
  assign link.host_data_out      = out;
  assign link.host_data_oe       = oe;

  assign take          = ready & (cmd_convert | cmd_read | cmd_write);
  assign cclk_fall_now = cclk & (half_cnt == adcp_pkg::CLK_HALF_CYCLES - 2'h1);

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      half_cnt <= 2'h0;
      cclk     <= 1'b0;
    end else if (half_cnt == adcp_pkg::CLK_HALF_CYCLES - 2'h1) begin
      half_cnt <= 2'h0;
      cclk     <= ~cclk;
    end else begin
      half_cnt <= half_cnt + 2'h1;
    end
  end

  // acquisition time counted while start is high
  always_ff @(posedge clk) begin
    if (!reset_n || !start_n) begin
      acq <= 4'h0;
    end else if (acq != adcp_pkg::ACQ_CYCLES) begin
      acq <= acq + 4'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ready <= 1'b0;
    end else begin
      ready <= (state == H_IDLE) && (acq == adcp_pkg::ACQ_CYCLES) && !take; // R6
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      busy_seen       <= 1'b0;
      conversion_done <= 1'b0;
    end else begin
      busy_seen       <= busy_s;
      conversion_done <= busy_seen & ~busy_s;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state <= H_PRIME; start_n <= 1'b0; cs_n <= 1'b1; rd_n <= 1'b1; wr_n <= 1'b1;
      word_mode <= 1'b1; out <= 12'h000; oe <= 12'h000; cnt <= 4'h0;
      is_write <= 1'b0; single <= 1'b0; need_high <= 1'b0; phase_high <= 1'b0;
      word_buf <= 12'h000; low_byte <= 8'h00;
      read_valid <= 1'b0; read_word <= 12'h000; read_channel <= 3'h0;
    end else begin
      read_valid <= 1'b0;
      case (state)
        H_PRIME: begin
          start_n <= 1'b1; // R7
          state   <= H_IDLE;
        end
        H_IDLE: begin
          cnt        <= 4'h0;
          phase_high <= 1'b0;
          word_mode  <= take ? word_mode_select : word_mode;
          if (take && cmd_convert) begin
            start_n <= 1'b0;
            state   <= H_CONV;
          end else if (take && cmd_read) begin
            is_write <= 1'b0;
            cs_n <= 1'b0; rd_n <= 1'b0;
            out  <= 12'h000;
            oe   <= word_mode_select ? 12'h000 : 12'h100; // R10
            state <= H_READ;
          end else if (take) begin
            is_write <= 1'b1;
            single   <= cmd_single;
            word_buf <= cmd_word;
            cs_n <= 1'b0; wr_n <= 1'b0;
            out  <= (word_mode_select && !cmd_single) ? cmd_word : {4'h0, cmd_word[7:0]};
            oe   <= word_mode_select ? 12'hFFF : 12'h1FF;
            state <= H_WRITE;
          end
        end
        H_CONV: begin
          if (cclk_fall_now && cnt != adcp_pkg::CONV_FALL_EDGE) begin
            cnt <= cnt + 4'h1;
          end
          if (cnt == adcp_pkg::CONV_FALL_EDGE && !busy_s) begin
            start_n <= 1'b1; // R3
            state   <= H_IDLE;
          end
        end
        H_READ: begin
          cnt <= cnt + 4'h1;
          if (cnt == adcp_pkg::READ_CYCLES - 4'h1) begin
            cs_n <= 1'b1; rd_n <= 1'b1; oe <= 12'h000; cnt <= 4'h0;
            state <= H_GAP;
            need_high <= !word_mode && !phase_high;
            if (word_mode) begin
              read_word  <= data_s;
              read_valid <= 1'b1;
            end else if (!phase_high) begin
              low_byte <= data_s[7:0];
            end else begin
              read_word    <= {data_s[3:0], low_byte};
              read_channel <= data_s[7:5];
              read_valid   <= 1'b1;
            end
          end
        end
        H_WRITE: begin
          cnt <= cnt + 4'h1;
          if (cnt == adcp_pkg::WR_LOW_CYCLES - 4'h1) begin
            cs_n <= 1'b1; wr_n <= 1'b1; cnt <= 4'h0;
            state <= H_WHOLD;
          end
        end
        H_WHOLD: begin
          cnt <= cnt + 4'h1;
          if (cnt == adcp_pkg::WR_HOLD_CYCLES - 4'h1) begin
            oe <= 12'h000; cnt <= 4'h0;
            need_high <= !word_mode && !single && !phase_high;
            state <= H_GAP;
          end
        end
        H_GAP: begin
          cnt <= cnt + 4'h1;
          if (cnt == adcp_pkg::GAP_CYCLES - 4'h1) begin
            cnt <= 4'h0;
            if (need_high) begin
              need_high  <= 1'b0;
              phase_high <= 1'b1;
              cs_n <= 1'b0;
              rd_n <= is_write;
              wr_n <= !is_write;
              out  <= is_write ? {3'h0, 1'b1, 4'h0, word_buf[11:8]} : 12'h100; // R16 R17
              oe   <= is_write ? 12'h1FF : 12'h100;
              state <= is_write ? H_WRITE : H_READ;
            end else begin
              state <= H_IDLE;
            end
          end
        end
        default: state <= H_IDLE;
      endcase
    end
  end
endmodule : adcp_host

/* File: hw/adcp_if.sv */
// Purpose: pins between the host and the converter port
// Assumes: one bit of enable per data line
// Notes:   bus level is the or of the enabled drivers

`timescale 1ns/10ps

interface adcp_if;
  logic                          conversion_start_n;
  logic                          conversion_clock;
  logic                          busy;
  logic                          cs_n;
  logic                          rd_n;
  logic                          wr_n;
  logic                          word_mode;
  logic [adcp_pkg::DATA_W-1:0]   host_data_out;
  logic [adcp_pkg::DATA_W-1:0]   host_data_oe;
  logic [adcp_pkg::DATA_W-1:0]   dev_data_out;
  logic [adcp_pkg::DATA_W-1:0]   dev_data_oe;
  logic [adcp_pkg::DATA_W-1:0]   data_bus;

  assign data_bus = (host_data_out & host_data_oe) | (dev_data_out & dev_data_oe);

  modport host (
    output conversion_start_n, conversion_clock, cs_n, rd_n, wr_n, word_mode,
    output host_data_out, host_data_oe,
    input  busy, data_bus
  );

  modport device (
    input  conversion_start_n, conversion_clock, cs_n, rd_n, wr_n, word_mode,
    input  data_bus,
    output busy, dev_data_out, dev_data_oe
  );
endinterface : adcp_if

/* File: hw/adcp_pkg.sv */
// Purpose: shared constants and types for the converter parallel port
// Assumes: 10 MHz system clock on both ends
// Notes:   control field positions are local choices

package adcp_pkg;

  localparam int          DATA_W          = 12;
  localparam int          BYTE_W          = 8;
  localparam int          CHAN_W          = 3;
  localparam int          HBS_BIT         = 8;

  localparam int          CLK_PERIOD_NS   = 100;
  localparam int          ACQ_TIME_NS     = 125;
  localparam logic [3:0]  ACQ_CYCLES      = 4'((ACQ_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  localparam logic [3:0]  TRACK_RISE_EDGE = 4'hD;
  localparam logic [3:0]  CONV_FALL_EDGE  = 4'hE;

  localparam int          PWR_LOW_BIT     = 4;
  localparam int          PWR_HIGH_BIT    = 5;
  localparam int          SHADOW_LOAD_BIT = 3;
  localparam int          CHAN_LSB        = 8;

  localparam logic [11:0] CONTROL_RESET   = 12'h000;
  localparam logic [7:0]  MASK_RESET      = 8'h00;
  localparam logic [11:0] RESULT_RESET    = 12'h000;

  localparam logic [1:0]  CLK_HALF_CYCLES = 2'h2;
  localparam logic [3:0]  READ_CYCLES     = 4'h7;
  localparam logic [3:0]  WR_LOW_CYCLES   = 4'h3;
  localparam logic [3:0]  WR_HOLD_CYCLES  = 4'h3;
  localparam logic [3:0]  GAP_CYCLES      = 4'h4;

  typedef enum logic [1:0] {
    PM_NORMAL        = 2'b00,
    PM_AUTO_SHUTDOWN = 2'b01,
    PM_AUTO_STANDBY  = 2'b10,
    PM_FULL_SHUTDOWN = 2'b11
  } adcp_power_t;

  // power mode held in a control word
  function automatic adcp_power_t adcp_power_of(input logic [11:0] word);
    adcp_power_of = adcp_power_t'({word[PWR_HIGH_BIT], word[PWR_LOW_BIT]});
  endfunction : adcp_power_of

endpackage : adcp_pkg

/* File: hw/adcp_sync.sv */
// Purpose: two flop synchroniser for a group of pins
// Assumes: each bit is an independent level
// Notes:   first stage feeds only the second

`timescale 1ns/10ps

module adcp_sync #(
  parameter int               WIDTH       = 1,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  logic [WIDTH-1:0] stage;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      stage <= RESET_VALUE;
      q     <= RESET_VALUE;
    end else begin
      stage <= d;
      q     <= stage;
    end
  end
endmodule : adcp_sync

/* File: verif/adcp_props.sv */
// Purpose: pin level checks between host and converter ends
// Assumes: both ends are design modules, one clock
// Notes:   busy length is counted in helper logic
`timescale 1ns/10ps
module adcp_props (
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic        conversion_start_n,
  input wire logic        conversion_clock,
  input wire logic        busy,
  input wire logic        cs_n,
  input wire logic        rd_n,
  input wire logic        wr_n,
  input wire logic        word_mode,
  input wire logic [11:0] host_data_out,
  input wire logic [11:0] host_data_oe,
  input wire logic [11:0] dev_data_oe
);
  localparam int BUSY_MIN = 44;
  localparam int BUSY_MAX = 68;
  logic [6:0] busy_cnt;
  logic       rd_act;
  assign rd_act = !cs_n && !rd_n;
  always_ff @(posedge clk) begin
    if (!reset_n || !busy) begin
      busy_cnt <= 7'h00;
    end else if (busy_cnt != 7'h7F) begin
      busy_cnt <= busy_cnt + 7'h01;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence s_start_fall;
    conversion_start_n ##1 !conversion_start_n [*3];
  endsequence
  sequence s_read_held;
    rd_act [*5];
  endsequence
  AST_BUSY_FOLLOWS: assert property (s_start_fall |-> ##[1:3] busy)
    else $error("busy missed start fall");
  AST_BUSY_CAUSE: assert property ($rose(busy) |-> !conversion_start_n)
    else $error("busy rose without start low");
  AST_BUSY_SPAN: assert property ($fell(busy) |-> busy_cnt >= BUSY_MIN && busy_cnt <= BUSY_MAX)
    else $error("conversion length wrong");
  AST_BUSY_BOUND: assert property (busy_cnt <= BUSY_MAX)
    else $error("busy stuck high");
  AST_START_RISE: assert property ($rose(conversion_start_n) |-> !busy)
    else $error("start raised during conversion");
  AST_OE_ON: assert property (s_read_held |-> |dev_data_oe)
    else $error("read not driven");
  AST_OE_CAUSE: assert property (|dev_data_oe |-> $past(rd_act, 2) || $past(rd_act, 3) || $past(rd_act, 4))
    else $error("bus driven without read");
  AST_NO_FIGHT: assert property ((dev_data_oe & host_data_oe) == 12'h000)
    else $error("both ends drive bus");
  AST_WR_DATA: assert property ($rose(wr_n) |-> (|host_data_oe && $stable(host_data_out)) [*3])
    else $error("write data not held");
  AST_HIGH_ZERO: assert property (!wr_n && !word_mode && host_data_oe[8] && host_data_out[8]
                                  |-> host_data_out[7:4] == 4'h0)
    else $error("high byte top bits set");
  AST_CLOCK_SHAPE: assert property ($rose(conversion_clock) |-> conversion_clock [*2] ##1 !conversion_clock [*2])
    else $error("conversion clock shape wrong");
endmodule : adcp_props

/* File: verif/testbench.sv */
// Purpose: host user side driven against the converter end
// Assumes: 12-bit device, commands only while ready
// Notes:   words from an lfsr seeded at 14
`timescale 1ns/10ps
module testbench;
  logic        clk;
  logic        reset_n;
  logic        cmd_convert;
  logic        cmd_read;
  logic        cmd_write;
  logic        cmd_single;
  logic [11:0] cmd_word;
  logic        word_mode_select;
  logic        ready;
  logic        read_valid;
  logic [11:0] read_word;
  logic [2:0]  read_channel;
  logic [11:0] sample_value;
  logic        hold;
  logic        powered_down;
  logic [11:0] control_word;
  logic [7:0]  channel_mask;
  logic [11:0] result_word;
  logic [2:0]  result_channel;
  logic [11:0] got_word;
  logic [2:0]  got_chan;
  logic [15:0] rnd;
  logic        conv_done;
  logic        busy_seen;
  int          reads = 0;
  int          dones = 0;
  int          pd_cycles = 0;
  int          errors;
  int          compares;
  int          cycles;
  adcp_if bus_if ();
  adcp_host u_adcp_host (.link(bus_if), .clk(clk), .reset_n(reset_n), .cmd_convert(cmd_convert),
    .cmd_read(cmd_read), .cmd_write(cmd_write), .cmd_single(cmd_single), .cmd_word(cmd_word),
    .word_mode_select(word_mode_select), .ready(ready), .busy_seen(busy_seen), .conversion_done(conv_done),
    .read_valid(read_valid), .read_word(read_word), .read_channel(read_channel));
  adcp_device u_adcp_device (.link(bus_if), .clk(clk), .reset_n(reset_n), .sample_value(sample_value),
    .hold(hold), .powered_down(powered_down), .control_word(control_word), .channel_mask(channel_mask),
    .result_word(result_word), .result_channel(result_channel));
  adcp_props u_adcp_props (.clk(clk), .reset_n(reset_n), .conversion_start_n(bus_if.conversion_start_n),
    .conversion_clock(bus_if.conversion_clock), .busy(bus_if.busy), .cs_n(bus_if.cs_n),
    .rd_n(bus_if.rd_n), .wr_n(bus_if.wr_n), .word_mode(bus_if.word_mode),
    .host_data_out(bus_if.host_data_out), .host_data_oe(bus_if.host_data_oe),
    .dev_data_oe(bus_if.dev_data_oe));

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr

  // control word with power and shadow flag bits cleared
  function automatic logic [11:0] safe_word(input logic [11:0] r);
    return r & 12'hFC7;
  endfunction : safe_word

  task automatic chk(input string name, input logic [11:0] seen, input logic [11:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic wrap_up();
    if (errors == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : wrap_up

  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ready !== 1'b1 && n < 400);
  endtask : wait_ready

  // kind bits: convert, read, write, single
  task automatic run(input logic [3:0] kind, input logic [11:0] word, input logic wm);
    wait_ready();
    {cmd_convert, cmd_read, cmd_write, cmd_single} <= kind;
    cmd_word <= word;
    word_mode_select <= wm;
    @(posedge clk);
    {cmd_convert, cmd_read, cmd_write, cmd_single} <= 4'h0;
    wait_ready();
  endtask : run

  always @(posedge clk) begin
    if (read_valid === 1'b1) begin
      got_word <= read_word;
      got_chan <= read_channel;
      reads++;
    end
    if (conv_done === 1'b1) begin
      dones++;
    end
    if (powered_down === 1'b1) begin
      pd_cycles++;
    end
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      wrap_up();
    end
  end

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  initial begin
    int          i;
    logic [11:0] w;
    int          pd0;
    reset_n = 1'b0;
    {cmd_convert, cmd_read, cmd_write, cmd_single} = 4'h0;
    cmd_word = 12'h000;
    word_mode_select = 1'b1;
    sample_value = 12'h000;
    rnd = 16'h000E;
    errors = 0;
    compares = 0;
    cycles = 0;
    repeat (6) @(posedge clk);
    chk("hold", 12'(hold), 12'h001);
    chk("pdown", 12'(powered_down), 12'h000);
    chk("ctrl", control_word, adcp_pkg::CONTROL_RESET);
    reset_n <= 1'b1;
    wait_ready();
    chk("track", 12'(hold), 12'h000);
    for (i = 0; i < 8; i++) begin
      rnd = lfsr(rnd);
      w = safe_word(rnd[11:0]);
      run(4'h2, w, i[0]);
      chk("ctrl", control_word, w);
      rnd = lfsr(rnd);
      sample_value <= (i == 0) ? 12'hFFF : (i == 1) ? 12'h000 : rnd[11:0];
      run(4'h8, w, 1'b1);
      chk("result", result_word, sample_value);
      chk("chan", 12'(result_channel), 12'(w[10:8]));
      chk("track", 12'(hold), 12'h000);
      chk("done", 12'(dones), 12'(i + 1));
      chk("bseen", 12'(busy_seen), 12'h000);
      run(4'h4, w, 1'b1);
      chk("word", got_word, sample_value);
      run(4'h4, w, 1'b0);
      chk("bytes", got_word, sample_value);
      chk("id", 12'(got_chan), 12'(w[10:8]));
      chk("reads", 12'(reads), 12'(2 * i + 2));
    end
    for (i = 0; i < 2; i++) begin
      run(4'h2, 12'h008, i[0]);
      run(4'h3, 12'h0A5 ^ 12'(i), i[0]);
      chk("mask", 12'(channel_mask), 12'h0A5 ^ 12'(i));
      chk("ctrl", control_word, 12'h008);
    end
    run(4'h2, 12'h030, 1'b1);
    chk("pdown", 12'(powered_down), 12'h001);
    chk("hold", 12'(hold), 12'h001);
    run(4'h2, 12'h000, 1'b1);
    chk("pdown", 12'(powered_down), 12'h000);
    chk("hold", 12'(hold), 12'h000);
    for (i = 1; i < 3; i++) begin
      run(4'h2, 12'(i) << 4, 1'b0);
      pd0 = pd_cycles;
      run(4'h8, 12'h000, 1'b1);
      chk("asleep", 12'(pd_cycles > pd0), 12'h001);
      repeat (4) @(posedge clk);
      chk("pdown", 12'(powered_down), 12'h000);
      chk("track", 12'(hold), 12'h000);
    end
    wrap_up();
  end
endmodule : testbench
